/* File: rtl/pll_div_pkg.sv */
// constants and carrier types for the main pll divider block
// assumes one 25 mhz system clock and an active-low async reset
package pll_div_pkg;

  // serial frame layout, first bit shifted in is bit 0
  localparam int unsigned FRAME_BITS  = 24;
  localparam int unsigned COUNT_W     = 5;
  localparam int unsigned DIVISOR_LSB = 0;
  localparam int unsigned DIVISOR_W   = 16;
  localparam int unsigned SEL_BIT     = 16;
  localparam int unsigned MODE_BIT    = 17;
  localparam int unsigned DIRECT_W    = 12;

  // frame length as a counter value
  localparam logic [COUNT_W-1:0] FRAME_COUNT = 5'h18;

  // reset values of the settings
  localparam logic [DIVISOR_W-1:0] DIVISOR_RST = 16'h0110;
  localparam logic                 SEL_RST     = 1'h0;
  localparam logic                 MODE_RST    = 1'h0;

  // documented divisor limits, not used by any check
  localparam logic [DIVISOR_W-1:0] SWALLOW_MIN = 16'h0110;
  localparam logic [DIRECT_W-1:0]  DIRECT_MIN  = 12'h005;

  // serial link sequencer, gray along idle-shift-close
  typedef enum logic [1:0] {
    LINK_IDLE  = 2'h0,
    LINK_SHIFT = 2'h1,
    LINK_CLOSE = 2'h3
  } link_state_type;

  // the five pins that need synchronising
  typedef struct packed {
    logic ce;
    logic cl;
    logic di;
    logic fm;
    logic am;
  } pin_type;

  // divider settings taken from a complete frame
  typedef struct packed {
    logic                 mode;
    logic                 sel;
    logic [DIVISOR_W-1:0] divisor;
  } settings_type;

  // whole state of the top module
  typedef struct packed {
    pin_type               meta;
    pin_type               sync;
    pin_type               prev;
    link_state_type        link;
    logic [FRAME_BITS-1:0] shift;
    logic [COUNT_W-1:0]    count;
    settings_type          settings;
    logic [DIVISOR_W+1:0]  readback;
    logic                  presc;
    logic                  do_oe_b;
    logic                  divided;
  } state_type;

endpackage : pll_div_pkg

/* File: rtl/rate_divider.sv */
// programmable event counter: one pulse every divisor_in events
// assumes event_in is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
module rate_divider #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_b_in,
  // events and setting
  input  wire logic             event_in,
  input  wire logic [WIDTH-1:0] divisor_in,
  // divided output
  output logic                  pulse_out
);

  // counter state kept as one struct
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             pulse;
  } div_state_type;

  div_state_type st;       // registered state
  div_state_type next_st;  // next state

  // count events; wrap at divisor minus one so the ratio is exact
  always_comb begin
    next_st       = st;
    next_st.pulse = 1'b0;
    if (event_in) begin
      // >= also recovers quickly when the divisor shrinks mid-count
      if (st.count >= divisor_in - WIDTH'(1)) begin
        next_st.count = '0;
        next_st.pulse = 1'b1;
      end else begin
        next_st.count = st.count + WIDTH'(1);
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse_out = st.pulse;

endmodule : rate_divider
`default_nettype wire

/* File: rtl/pll_programmable_divider.sv */
// main pll input selection, prescaler and programmable dividers,
// with the three-wire serial link that loads the settings
// assumes all pins are asynchronous to sys_clk_in and slower than it
//
// Behaviour
// - select bit 1 routes fm input
// - fm input halved before swallow counter
// - fm divisor 272..65535, total ratio doubled
// - select bit 0 routes am input
// - am swallow mode: direct, 272..65535
// - am direct mode: 12-bit divider, 5..4095
// - serial link active only while enable high
// - shift clock times serial in and out
`timescale 1ns/1ps
`default_nettype none
module pll_programmable_divider
  import pll_div_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  // serial link from the host
  input  wire logic chip_enable_in,
  input  wire logic serial_shift_clock_in,
  input  wire logic serial_data_in_in,
  // open-drain serial data back to the host
  output logic      serial_data_out_out,
  output logic      serial_data_out_oe_b_out,
  // local oscillator inputs
  input  wire logic fm_local_osc_input_in,
  input  wire logic am_local_osc_input_in,
  // divided signal and current settings
  output logic      divided_pulse_out,
  output logic      osc_input_select_out,
  output logic      am_divider_mode_out
);

  state_type st;       // registered state
  state_type next_st;  // next state

  // edges seen on the synchronised pins
  logic ce_rise;       // enable went high
  logic ce_fall;       // enable went low
  logic cl_rise;       // shift clock rising edge
  logic cl_fall;       // shift clock falling edge
  logic fm_rise;       // fm oscillator edge
  logic am_rise;       // am oscillator edge

  // events into the two counters
  logic swallow_event; // input to the 16-bit swallow counter
  logic direct_event;  // input to the 12-bit direct divider
  logic swallow_pulse; // swallow counter terminal count
  logic direct_pulse;  // direct divider terminal count
  logic use_swallow;   // swallow path is the active one

  // edge detectors compare the second sync stage with the edge stage after it
  assign ce_rise = st.sync.ce & ~st.prev.ce;
  assign ce_fall = ~st.sync.ce & st.prev.ce;
  assign cl_rise = st.sync.cl & ~st.prev.cl;
  assign cl_fall = ~st.sync.cl & st.prev.cl;
  assign fm_rise = st.sync.fm & ~st.prev.fm;
  assign am_rise = st.sync.am & ~st.prev.am;

  // input routing; fm edges count only every second one
  always_comb begin
    swallow_event = 1'b0;
    direct_event  = 1'b0;
    if (st.settings.sel) begin
      swallow_event = fm_rise & st.presc;
    end else if (st.settings.mode) begin
      swallow_event = am_rise;
    end else begin
      direct_event  = am_rise;
    end
  end

  assign use_swallow = st.settings.sel | st.settings.mode;

  // swallow counter; the prescaler doubles the fm ratio
  rate_divider #(
    .WIDTH      (DIVISOR_W)
  ) u_swallow (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .event_in   (swallow_event),
    .divisor_in (st.settings.divisor),
    .pulse_out  (swallow_pulse)
  );

  // direct divider uses only the low twelve bits
  rate_divider #(
    .WIDTH      (DIRECT_W)
  ) u_direct (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .event_in   (direct_event),
    .divisor_in (st.settings.divisor[DIRECT_W-1:0]),
    .pulse_out  (direct_pulse)
  );

  // next state of everything
  always_comb begin
    next_st      = st;
    // two-flop synchronisers, then one stage for edges
    next_st.meta = '{ce: chip_enable_in, cl: serial_shift_clock_in,
                     di: serial_data_in_in, fm: fm_local_osc_input_in,
                     am: am_local_osc_input_in};
    next_st.sync = st.meta;
    next_st.prev = st.sync;

    // divide-by-two prescaler runs only while fm is routed
    if (st.settings.sel && fm_rise) begin
      next_st.presc = ~st.presc;
    end

    // pick the output of whichever counter is routed
    next_st.divided = use_swallow ? swallow_pulse : direct_pulse;

    // serial link sequencer
    case (st.link)
      LINK_IDLE: begin
        next_st.do_oe_b = 1'b1;
        if (ce_rise) begin
          next_st.link     = LINK_SHIFT;
          next_st.count    = '0;
          next_st.readback = {st.settings.mode, st.settings.sel,
                              st.settings.divisor};
        end
      end
      LINK_SHIFT: begin
        if (ce_fall) begin
          next_st.link    = LINK_CLOSE;
          next_st.do_oe_b = 1'b1;
        end else begin
          // data taken on the rising shift clock edge
          if (cl_rise) begin
            next_st.shift = {st.sync.di, st.shift[FRAME_BITS-1:1]};
            if (st.count != FRAME_COUNT) begin
              next_st.count = st.count + COUNT_W'(1);
            end
          end
          // read-back bit changes on the falling edge; low pulls
          if (cl_fall) begin
            next_st.do_oe_b  = st.readback[0];
            next_st.readback = {1'b1, st.readback[DIVISOR_W+1:1]};
          end
        end
      end
      LINK_CLOSE: begin
        // short frames are dropped; long frames apply their last 24 bits
        if (st.count == FRAME_COUNT) begin
          next_st.settings.divisor =
            st.shift[DIVISOR_LSB +: DIVISOR_W];
          next_st.settings.sel  = st.shift[SEL_BIT];
          next_st.settings.mode = st.shift[MODE_BIT];
          next_st.presc         = 1'b0;
        end
        next_st.link = LINK_IDLE;
      end
      default: begin
        next_st.link = LINK_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st                  <= '0;
      st.link             <= LINK_IDLE;
      st.settings.divisor <= DIVISOR_RST;
      st.settings.sel     <= SEL_RST;
      st.settings.mode    <= MODE_RST;
      st.do_oe_b          <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs from flip-flops, except serial data out which is tied low
  assign serial_data_out_out      = 1'b0;
  assign serial_data_out_oe_b_out = st.do_oe_b;
  assign divided_pulse_out        = st.divided;
  assign osc_input_select_out     = st.settings.sel;
  assign am_divider_mode_out      = st.settings.mode;

  // checks

  property p_fm_route;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      st.settings.sel && fm_rise && st.presc |-> swallow_event;
  endproperty
  a_fm_route: assert property (p_fm_route)
    else $error("fm edge not routed while fm selected");

  property p_prescale;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      st.settings.sel && swallow_event |=> !st.presc;
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("fm edge counted without halving");

  property p_fm_half;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      st.settings.sel && fm_rise && !st.presc |-> !swallow_event;
  endproperty
  a_fm_half: assert property (p_fm_half)
    else $error("fm ratio not doubled");

  property p_am_route;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      !st.settings.sel && !am_rise |-> !swallow_event && !direct_event;
  endproperty
  a_am_route: assert property (p_am_route)
    else $error("fm edge leaked while am selected");

  property p_am_swallow;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      !st.settings.sel && st.settings.mode && am_rise
        |-> swallow_event && !direct_event;
  endproperty
  a_am_swallow: assert property (p_am_swallow)
    else $error("am swallow path misrouted");

  property p_am_direct;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      !st.settings.sel && !st.settings.mode && am_rise
        |-> direct_event && !swallow_event;
  endproperty
  a_am_direct: assert property (p_am_direct)
    else $error("am direct path misrouted");

  property p_ce_gate;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      !st.sync.ce && !st.prev.ce |=> $stable(st.shift) && st.do_oe_b;
  endproperty
  a_ce_gate: assert property (p_ce_gate)
    else $error("serial activity with enable low");

  property p_shift_in;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      st.link == LINK_SHIFT && !ce_fall && cl_rise
        |=> st.shift[FRAME_BITS-1] == $past(st.sync.di);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("data bit not taken on shift clock edge");

endmodule : pll_programmable_divider
`default_nettype wire

/* File: sim/lo_host_model.sv */
// host controller and local oscillator stand-in for the pll divider
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
`default_nettype none
module lo_host_model (
  // clock and open-drain read-back line
  input  wire logic sys_clk_in,
  input  wire logic do_line_in,
  // pins towards the divider
  output logic      ce_out,
  output logic      cl_out,
  output logic      di_out,
  output logic      fm_out,
  output logic      am_out
);
  // oscillator pins sit on pull-downs, shift clock parks low
  initial {ce_out, cl_out, di_out, fm_out, am_out} = 5'h00;

  // wait n system cycles, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick

  // one transfer, lsb first; read-back taken late in each low phase
  task automatic send_frame(input logic [23:0] f, input int nbits,
                            output logic [23:0] rb);
    rb = '1;
    ce_out = 1'b1;
    tick(4);
    for (int i = 0; i < nbits; i++) begin
      di_out = f[i];
      tick(4);
      cl_out = 1'b1;
      tick(5);
      cl_out = 1'b0;
      tick(6);
      rb[i] = do_line_in;
    end
    // enable only drops after the last clock, data line goes stale
    ce_out = 1'b0;
    di_out = ~di_out;
    tick(8);
  endtask : send_frame

  // n rising edges, eight system cycles apart, on one oscillator pin
  task automatic osc_edges(input logic use_fm, input int n);
    repeat (n) begin
      if (use_fm) begin
        fm_out = 1'b1;
      end else begin
        am_out = 1'b1;
      end
      tick(4);
      fm_out = 1'b0;
      am_out = 1'b0;
      tick(4);
    end
  endtask : osc_edges
endmodule : lo_host_model
`default_nettype wire

/* File: sim/pll_programmable_divider_tb_top.sv */
// self-checking bench for the main pll divider and its serial link
// assumes lo_host_model stands in for the host and both oscillators
`timescale 1ns/1ps
`default_nettype none
module pll_programmable_divider_tb_top;
  import pll_div_pkg::*;
  logic        sys_clk = 1'b0;       // 25 mhz system clock
  logic        rst_b   = 1'b0;       // async reset, low active
  logic        ce, cl, di, fm, am;   // pins from the host model
  logic        do_val, do_oe_b;      // open-drain read-back
  logic        do_line;              // resolved read-back wire
  logic        divided, sel, mode;   // divider outputs
  logic [23:0] rb;                   // read-back of one frame
  int          n_mismatch = 0;
  int          check_count = 0;
  int          edges = 0;            // oscillator rises so far
  int          last = 0;             // edge count at last pulse
  int          gaps[$];              // edges between pulses

  always #20 sys_clk = ~sys_clk;
  // host side holds a pull-up on the read-back line
  assign do_line = do_oe_b ? 1'b1 : do_val;

  pll_programmable_divider u_dut (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .chip_enable_in(ce),
    .serial_shift_clock_in(cl), .serial_data_in_in(di),
    .serial_data_out_out(do_val), .serial_data_out_oe_b_out(do_oe_b),
    .fm_local_osc_input_in(fm), .am_local_osc_input_in(am),
    .divided_pulse_out(divided), .osc_input_select_out(sel),
    .am_divider_mode_out(mode));

  lo_host_model host (
    .sys_clk_in(sys_clk), .do_line_in(do_line), .ce_out(ce),
    .cl_out(cl), .di_out(di), .fm_out(fm), .am_out(am));

  // pins change 1 ns after the clock, so no race with this sampling
  always @(posedge fm or posedge am) edges++;
  always @(posedge sys_clk) begin
    if (divided === 1'b1) begin
      gaps.push_back(edges - last);
      last = edges;
    end
  end

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_num(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_num

  // read-back shows the settings in force before this frame lands
  task automatic frame(input logic [23:0] f, input int nb,
                       input logic [23:0] exp_rb);
    host.send_frame(f, nb, rb);
    check_val(rb, exp_rb);
    check_val(do_oe_b, 1'b1);
  endtask : frame

  // first gap is phase-dependent, so only a later one is judged
  task automatic ratio(input logic use_fm, input int exp);
    gaps.delete();
    host.osc_edges(use_fm, 3 * exp + 2);
    check_num(gaps.size() >= 2, 1);
    if (gaps.size() >= 2) begin
      check_num(gaps[$], exp);
    end
  endtask : ratio

  task automatic t_reset;
    check_val({sel, mode, divided, do_oe_b}, 4'h1);
    frame({8'h00, 16'h0005}, 24, {6'h3f, 18'h00110});
    $display("test reset done");
  endtask : t_reset

  task automatic t_am_direct;
    check_val({sel, mode}, 2'h0);
    ratio(1'b0, 5);
    frame({8'h02, 16'h0110}, 24, {6'h3f, 18'h00005});
    $display("test am direct done");
  endtask : t_am_direct

  task automatic t_am_swallow;
    check_val({sel, mode}, 2'h1);
    ratio(1'b0, 272);
    frame({8'h01, 16'h0110}, 24, {6'h3f, 18'h20110});
    $display("test am swallow done");
  endtask : t_am_swallow

  task automatic t_fm;
    check_val({sel, mode}, 2'h2);
    gaps.delete();
    host.osc_edges(1'b0, 20);
    check_num(gaps.size(), 0);
    ratio(1'b1, 544);
    $display("test fm done");
  endtask : t_fm

  // a frame one bit short must leave the settings alone
  task automatic t_short;
    frame({8'h00, 16'h0005}, 23, {6'h3f, 18'h10110});
    check_val({sel, mode}, 2'h2);
    $display("test short frame done");
  endtask : t_short

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    @(posedge sys_clk);
    #1;
    t_reset;
    t_am_direct;
    t_am_swallow;
    t_fm;
    t_short;
    wrap_up;
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up;
  end
endmodule : pll_programmable_divider_tb_top
`default_nettype wire
